// ### verilog/ipw_cfg.svh
`ifndef IPW_CFG_SVH
`define IPW_CFG_SVH

// ------------------------------------------------------------
// Register map and field layout
// ------------------------------------------------------------
`define IPW_CFG_ADDR 16'hF1C0
`define IPW_CFG_RESET 16'h0000
`define IPW_VARIANT_SEL_BIT 5
`define IPW_FIELD_W 2
`define IPW_PINS 8
`define IPW_FREE_PINS 4

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IPW_CLK_PERIOD_NS 40
`define IPW_WAKE_MIN_NS 40
`define IPW_WAKE_CYCLES \
	((`IPW_WAKE_MIN_NS + `IPW_CLK_PERIOD_NS - 1) / `IPW_CLK_PERIOD_NS)

`endif

// ### verilog/ipw_pkg.sv
package ipw_pkg;

	// Power-down sequencer states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_DRAIN,
		ST_DOWN,
		ST_WAKE,
		ST_NEXT,
		ST_SERVICE
	} ipw_state_t;

	// Per-pin entry/exit level selection
	typedef enum logic [1:0] {
		FLD_UNUSED = 2'h0,
		FLD_ENTER_LOW = 2'h1,
		FLD_ENTER_HIGH = 2'h2,
		FLD_ANY_CHANGE = 2'h3
	} ipw_field_t;

endpackage : ipw_pkg

// ### verilog/ipw_wake_detect.sv
`timescale 1ns/100ps
`include "ipw_cfg.svh"

module ipw_wake_detect
	import ipw_pkg::*;
(
	input wire logic [15:0] edgeCfg,
	input wire logic [7:0] pinLevel,
	input wire logic [7:0] entryLevel,
	output logic [7:0] pinInactive,
	output logic [7:0] pinWake
);

	// ------------------------------------------------------------
	// Per-pin level decode
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `IPW_PINS; i++)
		begin : g_pin
			ipw_field_t field;
			assign field = ipw_field_t'(edgeCfg[2*i+1:2*i]);
			// Pins are looked at as plain levels here
			always_comb
			begin
				unique case (field)
					FLD_UNUSED:
					begin
						pinInactive[i] = 1'b1;
						pinWake[i] = 1'b0;
					end
					FLD_ENTER_LOW:
					begin
						pinInactive[i] = ~pinLevel[i];
						pinWake[i] = pinLevel[i];
					end
					FLD_ENTER_HIGH:
					begin
						pinInactive[i] = pinLevel[i];
						pinWake[i] = ~pinLevel[i];
					end
					FLD_ANY_CHANGE:
					begin
						pinInactive[i] = 1'b1;
						pinWake[i] = pinLevel[i] ^ entryLevel[i];
					end
				endcase
			end
		end
	endgenerate

endmodule : ipw_wake_detect

// ### verilog/ipw_powerdown.sv
`timescale 1ns/100ps
`include "ipw_cfg.svh"

module ipw_powerdown
	import ipw_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [15:0] sfrWrData,
	input wire logic sfrRdEn,
	output logic [15:0] sfrRdData,
	input wire logic [15:0] sysConfig,
	input wire logic pdInstr,
	input wire logic busBusy,
	input wire logic [7:0] fastWakePin,
	input wire logic [7:0] irqEnable,
	input wire logic [7:0] irqFlagClear,
	input wire logic resetInputPin_n,
	input wire logic delayBelowThresh,
	output logic [7:0] irqRequestFlag,
	output logic oscPllEnable,
	output logic pulldownEnable,
	output logic clocksGated,
	output logic unitsHold,
	output logic pdActive,
	output logic entryRefused,
	output logic resumeNext,
	output logic serviceReq,
	output logic [7:0] serviceSrc
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	ipw_state_t state_q, state_d;
	logic [15:0] cfg_q, cfg_d;
	logic [15:0] rdData_q, rdData_d;
	logic [7:0] entryLevel_q, entryLevel_d;
	logic [7:0] wakeSrc_q, wakeSrc_d;
	logic [7:0] flag_q, flag_d;
	logic [3:0] holdCnt_q, holdCnt_d;
	logic clkGate_q, clkGate_d;
	logic refused_q, refused_d;
	logic [7:0] pinInactive;
	logic [7:0] pinWake;
	logic [7:0] allowMask;
	logic [7:0] eligible;
	logic [7:0] flagKeep;
	logic [3:0] holdNext;
	logic cfgHit;
	logic allInactive;
	logic variantSel;

	// Level decode of the wake pins
	ipw_wake_detect u_detect (
		.edgeCfg(cfg_q),
		.pinLevel(fastWakePin),
		.entryLevel(entryLevel_q),
		.pinInactive(pinInactive),
		.pinWake(pinWake)
	);

	// Wake qualification terms
	assign cfgHit = (sfrAddr == `IPW_CFG_ADDR);
	assign variantSel = sysConfig[`IPW_VARIANT_SEL_BIT];
	assign allInactive = &pinInactive;
	assign allowMask = {irqEnable[7:4], 4'hF};
	assign eligible = pinWake & allowMask;
	assign holdNext = holdCnt_q + 4'h1;
	assign flagKeep = flag_q & ~irqFlagClear;

	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	always_comb
	begin
		cfg_d = cfg_q;
		if (sfrWrEn && cfgHit)
			cfg_d = sfrWrData;
		rdData_d = 16'h0000;
		if (sfrRdEn && cfgHit)
			rdData_d = cfg_q;
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		entryLevel_d = entryLevel_q;
		wakeSrc_d = wakeSrc_q;
		holdCnt_d = 4'h0;
		clkGate_d = clkGate_q;
		refused_d = 1'b0;
		flag_d = flagKeep;
		unique case (state_q)
			ST_RUN, ST_DRAIN:
			begin
				if ((state_q == ST_DRAIN) || (pdInstr && variantSel))
				begin
					if (busBusy)
						state_d = ST_DRAIN;
					else if (allInactive)
					begin
						state_d = ST_DOWN;
						entryLevel_d = fastWakePin;
						clkGate_d = 1'b1;
					end
					else
					begin
						state_d = ST_RUN;
						refused_d = 1'b1;
					end
				end
			end
			ST_DOWN:
			begin
				if (!resetInputPin_n)
				begin
					state_d = ST_RUN;
					clkGate_d = 1'b0;
				end
				else if (|eligible)
				begin
					// Count the cycles a wake level is held
					holdCnt_d = holdNext;
					if (holdNext >= 4'(`IPW_WAKE_CYCLES))
					begin
						state_d = ST_WAKE;
						wakeSrc_d = eligible;
						flag_d = flagKeep | eligible;
					end
				end
			end
			ST_WAKE:
			begin
				if (!resetInputPin_n)
				begin
					state_d = ST_RUN;
					clkGate_d = 1'b0;
				end
				else if (delayBelowThresh)
				begin
					state_d = ST_NEXT;
					clkGate_d = 1'b0;
				end
			end
			ST_NEXT:
			begin
				// Next instruction first, then service if enabled
				if (|(wakeSrc_q & irqEnable))
					state_d = ST_SERVICE;
				else
					state_d = ST_RUN;
			end
			ST_SERVICE:
			begin
				state_d = ST_RUN;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_RUN;
			cfg_q <= `IPW_CFG_RESET;
			rdData_q <= 16'h0000;
			entryLevel_q <= 8'h00;
			wakeSrc_q <= 8'h00;
			flag_q <= 8'h00;
			holdCnt_q <= 4'h0;
			clkGate_q <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			rdData_q <= rdData_d;
			entryLevel_q <= entryLevel_d;
			wakeSrc_q <= wakeSrc_d;
			flag_q <= flag_d;
			holdCnt_q <= holdCnt_d;
			clkGate_q <= clkGate_d;
			refused_q <= refused_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sfrRdData = rdData_q;
	assign irqRequestFlag = flag_q;
	assign clocksGated = clkGate_q;
	assign unitsHold = clkGate_q;
	assign oscPllEnable = (state_q != ST_DOWN);
	assign pulldownEnable = (state_q == ST_WAKE);
	assign pdActive = (state_q == ST_DOWN);
	assign entryRefused = refused_q;
	assign resumeNext = (state_q == ST_NEXT);
	assign serviceReq = (state_q == ST_SERVICE);
	assign serviceSrc = wakeSrc_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_variant_gate: assert property (
		state_q == ST_RUN && pdInstr && !variantSel |=> state_q == ST_RUN)
		else $error("entry taken without interruptible variant");
	a_enter_inactive: assert property (
		state_q != ST_DOWN ##1 state_q == ST_DOWN |-> $past(allInactive))
		else $error("entered power-down with an active pin");
	a_refuse_active: assert property (
		state_q == ST_RUN && pdInstr && variantSel && !busBusy
		&& !allInactive |=> entryRefused && state_q == ST_RUN)
		else $error("active pin did not refuse entry");
	a_reset_exit: assert property (
		(state_q == ST_DOWN || state_q == ST_WAKE) && !resetInputPin_n
		|=> state_q == ST_RUN && !clocksGated)
		else $error("reset pin did not end power-down");
	a_free_pin_wake: assert property (
		state_q == ST_DOWN && resetInputPin_n && |pinWake[3:0]
		|=> state_q == ST_WAKE ##0 flag_q != 8'h00)
		else $error("low pin did not wake");
	a_wake_osc: assert property (
		state_q == ST_WAKE |-> oscPllEnable && pulldownEnable && clocksGated)
		else $error("oscillator or pull-down off while waking");
	a_clock_gate: assert property (
		state_q == ST_WAKE && resetInputPin_n && !delayBelowThresh
		|=> clocksGated)
		else $error("clocks ungated before threshold");
	a_clock_release: assert property (
		state_q == ST_WAKE && resetInputPin_n && delayBelowThresh
		|=> !clocksGated ##0 resumeNext)
		else $error("threshold did not release clocks");
	a_next_first: assert property (
		state_q == ST_NEXT && |(wakeSrc_q & irqEnable)
		|-> !serviceReq ##1 serviceReq ##1 state_q == ST_RUN)
		else $error("service order wrong after wake");
	a_flag_hold: assert property (
		1'b1 |=> (flag_q & $past(flagKeep)) == $past(flagKeep))
		else $error("request flag lost before software clear");
	a_hold_units: assert property (
		state_q == ST_DOWN |-> unitsHold && !oscPllEnable)
		else $error("units not held in power-down");
	a_drain_bus: assert property (
		state_q == ST_DRAIN && busBusy |=> state_q == ST_DRAIN)
		else $error("power-down entered during bus cycle");
	a_cfg_write: assert property (
		sfrWrEn && cfgHit |=> cfg_q == $past(sfrWrData))
		else $error("config register write not stored");

	c_enter: cover property (state_q == ST_DRAIN ##1 state_q == ST_DOWN);
	c_pin_wake: cover property (state_q == ST_DOWN ##1 state_q == ST_WAKE);
	c_reset_exit: cover property (state_q == ST_WAKE ##1 state_q == ST_RUN);
	c_service: cover property (resumeNext ##1 serviceReq);

endmodule : ipw_powerdown

// ### dv/ipw_wake_partner.sv
`timescale 1ns/100ps

// ------------------------------------------
// Wake sources, reset circuit and delay pin
// ------------------------------------------
module ipw_wake_partner
	import ipw_pkg::*;
#(
	parameter int DISCHARGE = 3,
	parameter int SETTLE = 4
)
(
	input wire logic clk,
	input wire logic pulldownEnable,
	input wire logic [7:0] pinDrive,
	input wire logic rstPinReq,
	output logic [7:0] fastWakePin,
	output logic resetInputPin_n,
	output logic delayBelowThresh
);
	int settleCnt = 0;
	int dischargeCnt = 0;

	// Reset hold time and capacitor discharge, in clock cycles
	always @(posedge clk)
	begin
		if (rstPinReq)
			settleCnt <= SETTLE;
		else if (settleCnt != 0)
			settleCnt <= settleCnt - 1;
		if (pulldownEnable)
			dischargeCnt <= dischargeCnt + 1;
		else
			dischargeCnt <= 0; // Capacitor recharges when released
	end

	// Pins follow whatever level the bench drives, with no hold or delay
	assign fastWakePin = pinDrive;
	assign resetInputPin_n = (settleCnt == 0);
	assign delayBelowThresh = (dischargeCnt >= DISCHARGE);
endmodule : ipw_wake_partner

// ### dv/tb.sv
`timescale 1ns/100ps
`include "ipw_cfg.svh"

module tb
	import ipw_pkg::*;
;
	logic clk, rst_n, sfrWrEn, sfrRdEn, pdInstr, busBusy, rstPinReq;
	logic [15:0] sfrAddr, sfrWrData, sfrRdData, sysConfig;
	logic [7:0] pinDrive, fastWakePin, irqEnable, irqFlagClear;
	logic [7:0] irqRequestFlag, serviceSrc;
	logic resetInputPin_n, delayBelowThresh, oscPllEnable, pulldownEnable;
	logic clocksGated, unitsHold, pdActive, entryRefused, resumeNext;
	logic serviceReq;
	int errCount = 0;
	int checksDone = 0;

	// ----------------------
	// Design and far side
	// ----------------------
	ipw_powerdown dut (.clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrWrData,
		.sfrRdEn, .sfrRdData, .sysConfig, .pdInstr, .busBusy, .fastWakePin,
		.irqEnable, .irqFlagClear, .resetInputPin_n, .delayBelowThresh,
		.irqRequestFlag, .oscPllEnable, .pulldownEnable, .clocksGated,
		.unitsHold, .pdActive, .entryRefused, .resumeNext, .serviceReq,
		.serviceSrc);
	ipw_wake_partner #(.DISCHARGE(3), .SETTLE(4)) farSide (.clk,
		.pulldownEnable, .pinDrive, .rstPinReq, .fastWakePin,
		.resetInputPin_n, .delayBelowThresh);

	// 25 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// ----------------------
	// Tasks
	// ----------------------
	// Compare one value and count it
	task check(input logic [15:0] seen, input logic [15:0] exp);
		begin
			checksDone++;
			if (seen !== exp)
			begin
				errCount++;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask : check

	// Register write, one strobe cycle
	task wr(input logic [15:0] addr, input logic [15:0] data);
		begin
			sfrAddr = addr;
			sfrWrData = data;
			sfrWrEn = 1'h1;
			@(negedge clk);
			sfrWrEn = 1'h0;
		end
	endtask : wr

	// Register read; data is valid the cycle after the strobe
	task rd(input logic [15:0] addr, input logic [15:0] exp);
		begin
			sfrAddr = addr;
			sfrRdEn = 1'h1;
			@(negedge clk);
			sfrRdEn = 1'h0;
			check(sfrRdData, exp);
			@(negedge clk);
		end
	endtask : rd

	// Power-down instruction pulse, after one idle cycle so that two
	// calls in a row never re-raise the strobe in the same time step
	task pd();
		begin
			@(negedge clk);
			pdInstr = 1'h1;
			@(negedge clk);
			pdInstr = 1'h0;
		end
	endtask : pd

	// Wake from power-down through the pins in lvl, then resume
	task wake_via(input logic [7:0] lvl, input logic [7:0] src,
		input logic svc);
		int n;
		begin
			check(pdActive, 1'h1);
			check(oscPllEnable, 1'h0);
			check(unitsHold, 1'h1);
			pinDrive = lvl;
			@(negedge clk);
			pinDrive = 8'h02;
			check(oscPllEnable, 1'h1);
			check(pulldownEnable, 1'h1);
			check(irqRequestFlag & src, src);
			n = 0;
			while (resumeNext !== 1'h1 && n < 20)
			begin
				check(clocksGated, 1'h1);
				@(negedge clk);
				n++;
			end
			check(resumeNext, 1'h1);
			check(clocksGated, 1'h0);
			check(serviceSrc, src);
			@(negedge clk);
			check(serviceReq, svc);
			@(negedge clk);
		end
	endtask : wake_via

	// Print counts and verdict, end the run
	task print_verdict();
		begin
			$display("checks %0d mismatches %0d", checksDone, errCount);
			if (errCount == 0 && checksDone > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask : print_verdict

	// Watchdog, far beyond the sixty or so cycles needed
	initial
	begin
		#(40 * 3000);
		errCount++;
		print_verdict();
	end

	// ----------------------
	// Test sequence
	// ----------------------
	initial
	begin
		{rst_n, sfrWrEn, sfrRdEn, pdInstr, busBusy, rstPinReq} = 6'h00;
		{sfrAddr, sfrWrData, sysConfig} = 48'h0;
		{pinDrive, irqEnable, irqFlagClear} = 24'h020000;
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		@(negedge clk);
		check(clocksGated, 1'h0);
		rd(`IPW_CFG_ADDR, 16'h0000);
		wr(`IPW_CFG_ADDR, 16'hA5C3);
		rd(`IPW_CFG_ADDR, 16'hA5C3);
		wr(16'hF1C2, 16'h1234);
		rd(16'hF1C2, 16'h0000);
		rd(`IPW_CFG_ADDR, 16'hA5C3);
		// Pin 0 enter low, pin 1 enter high, pin 2 any, pin 5 enter low
		wr(`IPW_CFG_ADDR, 16'h0439);
		pd();
		check(pdActive, 1'h0);
		sysConfig = 16'h0020;
		pinDrive = 8'h03;
		pd();
		check(entryRefused, 1'h1);
		check(pdActive, 1'h0);
		pinDrive = 8'h02;
		busBusy = 1'h1;
		pd();
		repeat (2) @(negedge clk);
		check(pdActive, 1'h0);
		busBusy = 1'h0;
		repeat (2) @(negedge clk);
		irqEnable = 8'h01;
		wake_via(8'h03, 8'h01, 1'h1);
		irqEnable = 8'h00;
		pd();
		wake_via(8'h00, 8'h02, 1'h0);
		check(irqRequestFlag, 8'h03);
		pd();
		wake_via(8'h06, 8'h04, 1'h0);
		pd();
		// Pin 5 without its enable and unused pin 3 must not wake
		pinDrive = 8'h2A;
		repeat (2) @(negedge clk);
		check(pdActive, 1'h1);
		rstPinReq = 1'h1;
		@(negedge clk);
		rstPinReq = 1'h0;
		repeat (6) @(negedge clk);
		check(pdActive, 1'h0);
		check(clocksGated, 1'h0);
		pinDrive = 8'h02;
		irqFlagClear = 8'hFF;
		@(negedge clk);
		irqFlagClear = 8'h00;
		check(irqRequestFlag, 8'h00);
		print_verdict();
	end
endmodule : tb
